// *** shared/mt_cfg.svh ***
// Purpose: offsets, field positions, reset values and vectors of the peripheral cluster
// Assumes: 5-bit nibble-register address space
// Notes:   included by the design file
`ifndef MT_CFG_SVH
`define MT_CFG_SVH
`define MT_A_IRQ_EN    5'h00
`define MT_A_IRQ_REQ   5'h01
`define MT_A_TMR_PRESC 5'h02
`define MT_A_TMR_LO    5'h04
`define MT_A_TMR_HI    5'h05
`define MT_A_PORT_A    5'h08
`define MT_A_PORT_B    5'h09
`define MT_A_PORT_C    5'h0a
`define MT_A_PORT_D    5'h0b
`define MT_A_PORT_E    5'h0c
`define MT_A_CARR_OUT  5'h0d
`define MT_A_PULL      5'h13
`define MT_A_DIR_A     5'h16
`define MT_A_DIR_B     5'h17
`define MT_A_DIR_C     5'h18
`define MT_A_DIR_D     5'h19
`define MT_A_DIR_E     5'h1a
`define MT_A_CLW_LO    5'h1b
`define MT_A_CLW_HI    5'h1c
`define MT_A_CHW_LO    5'h1d
`define MT_A_CHW_HI    5'h1e
`define MT_B_TMR_IRQ   2
`define MT_B_PIN_IRQ   0
`define MT_B_PULL      3
`define MT_CNT_WRAP    8'hff
`define MT_VEC_RESET   10'h000
`define MT_VEC_TMR     10'h002
`define MT_VEC_PIN     10'h004
`define MT_RST_NIB     4'h0
`define MT_RST_BYTE    8'h00
`endif

// *** shared/mt_pkg.sv ***
// Purpose: types shared by the peripheral cluster
// Assumes: nothing
// Notes:   pin groups are ports a..e, msb first
`default_nettype none
package mt_pkg;
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [4:0] addr;
        logic [3:0] wdata;
    } mt_bus_req_t;
    typedef struct packed {
        logic       entry;
        logic [9:0] vector;
    } mt_irq_entry_t;
    typedef struct packed {
        logic [3:0] a;
        logic [3:0] b;
        logic [3:0] c;
        logic [2:0] d;
        logic [1:0] e;
    } mt_pins_t;
endpackage
`default_nettype wire

// *** hw/mt_periph.sv ***
// Purpose: timer, ports, carrier synthesizer and interrupt logic of a 4-bit mcu
// Assumes: core_clk 40 MHz, arst_n asynchronous active low
// Notes:   registers reached by a one-cycle strobe port, read data one cycle later
// Function
// R1: software writes timer reload low nibble, then high nibble which commits it
// R2: count reloads on high reload nibble write and on wrap from ff to 00
// R3: count read as high nibble first, which latches the low nibble for next read
// R4: timer wrap sets timer request; enabled request is serviced and wakes halt
// R5: timer advances per prescaler pulse, select 0..7 divides by 2^11..2^0
// R6: direction bit 1 drives pin, 0 makes input, all zero after reset
// R7: ports a,b,c four bits; d two plus input-only bit0; e two bits
// R8: global pull-low enable gates each pin pull-low, which follows its data bit
// R9: global pull-low enable is bit 3 of pull register, reset 0
// R10: rising edge on input pins of ports b or c sets port request
// R11: with port option high, port d inputs also raise port request
// R12: after a port request, no new one until all source inputs are low
// R13: carrier prescale select divides clock with same codes as timer
// R14: carrier uses 8-bit up-counter and high and low 8-bit reload registers
// R15: writes to carrier reload registers initialize the carrier counter
// R16: after reset carrier counter loads high reload and output goes high; carrier_out here resets to 0 and stays low until the control bit is set
// R17: each carrier wrap loads opposite phase reload and switches output level
// R18: carrier output bit written sets output control, read returns pin level
// R19: interrupt enable and request flags are read-write and reset to 0
// R20: enables at 00, requests at 01; timer bit 2, port bit 0
// R21: enabled pending request triggers context save and jump to priority vector
// R22: entering an interrupt clears all enable flags
// R23: timer vector 002, port vector 004, reset vector 000
// R24: software clears request flags by writing 0 before re-enabling
//
// Added by the designer: the strobed register port.
`include "mt_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module mt_periph (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    // register port
    input  wire mt_pkg::mt_bus_req_t   bus_req,
    output logic [3:0]                 bus_rdata,
    // board pins
    input  wire mt_pkg::mt_pins_t      pin_in,
    output mt_pkg::mt_pins_t           pin_out,
    output mt_pkg::mt_pins_t           pin_oe,
    output mt_pkg::mt_pins_t           pin_pull_low,
    input  wire logic                  opt_port_d_irq,
    output logic                       carrier_out,
    // core interface
    output mt_pkg::mt_irq_entry_t      irq_entry
);

    ////////////////////////////////////////////////////////////////////////
    function automatic logic hit(input mt_pkg::mt_bus_req_t r, input logic w,
                                 input logic [4:0] a);
        hit = (w ? r.wr : r.rd) && (r.addr == a);
    endfunction

    // one pulse every 2^k clocks from the shared free-running divider
    function automatic logic presc_tick(input logic [2:0] sel, input logic [10:0] c);
        case (sel)
            3'h0: presc_tick = &c[10:0];
            3'h1: presc_tick = &c[8:0];
            3'h2: presc_tick = &c[6:0];
            3'h3: presc_tick = &c[4:0];
            3'h4: presc_tick = &c[2:0];
            3'h5: presc_tick = &c[1:0];
            3'h6: presc_tick = c[0];
            default: presc_tick = 1'b1;
        endcase
    endfunction

    mt_pkg::mt_pins_t  pin_meta_q;
    mt_pkg::mt_pins_t  pin_sync_q;
    mt_pkg::mt_pins_t  data_q;
    mt_pkg::mt_pins_t  dir_q;
    mt_pkg::mt_pins_t  port_val;
    logic              opt_meta_q;
    logic              opt_sync_q;
    logic [10:0]       div_q;
    logic [2:0]        tsel_q;
    logic [7:0]        reload_q;
    logic [7:0]        tcnt_q;
    logic [3:0]        tc_lo_q;
    logic              tick_t;
    logic              tmr_wr_hi;
    logic              tmr_wrap;
    logic              pull_en_q;
    logic [2:0]        csel_q;
    logic [7:0]        low_w_q;
    logic [7:0]        high_w_q;
    logic [7:0]        low_w_d;
    logic [7:0]        high_w_d;
    logic [7:0]        ccnt_q;
    logic              phase_q;
    logic              carrier_output_ctl_bit_q;
    logic              tick_c;
    logic              carr_wr;
    logic              carr_wrap;
    logic [10:0]       src;
    logic [10:0]       src_prev_q;
    logic              armed_q;
    logic              pin_set;
    logic              ie_tmr_q;
    logic              ie_pin_q;
    logic              rq_tmr_q;
    logic              rq_pin_q;
    logic              pend_t;
    logic              pend_p;
    logic [3:0]        rd_mux;

    ////////////////////////////////////////////////////////////////////////
    // pin and option synchronisers
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
            opt_meta_q <= 1'b0;
            opt_sync_q <= 1'b0;
        end else begin
            pin_meta_q <= pin_in;
            pin_sync_q <= pin_meta_q;
            opt_meta_q <= opt_port_d_irq;
            opt_sync_q <= opt_meta_q;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q <= 11'h000;
        end else begin
            div_q <= div_q + 11'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interval timer
    assign tick_t    = presc_tick(tsel_q, div_q); // [R5]
    assign tmr_wr_hi = hit(bus_req, 1'b1, `MT_A_TMR_HI);
    assign tmr_wrap  = tick_t && (tcnt_q == `MT_CNT_WRAP) && !tmr_wr_hi;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tsel_q <= 3'h0;
        end else if (hit(bus_req, 1'b1, `MT_A_TMR_PRESC)) begin
            tsel_q <= bus_req.wdata[2:0];
        end
    end

    // low nibble lands in reload_q at once; the high nibble write also loads the count with both
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            reload_q <= `MT_RST_BYTE;
        end else if (hit(bus_req, 1'b1, `MT_A_TMR_LO)) begin
            reload_q[3:0] <= bus_req.wdata; // [R1]
        end else if (tmr_wr_hi) begin
            reload_q[7:4] <= bus_req.wdata; // [R1]
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tcnt_q <= `MT_RST_BYTE;
        end else if (tmr_wr_hi) begin
            tcnt_q <= {bus_req.wdata, reload_q[3:0]}; // [R2]
        end else if (tmr_wrap) begin
            tcnt_q <= reload_q; // [R2]
        end else if (tick_t) begin
            tcnt_q <= tcnt_q + 8'h01; // [R5]
        end
    end

    // high read freezes the low nibble so a carry between reads cannot tear the pair
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            tc_lo_q <= `MT_RST_NIB;
        end else if (hit(bus_req, 1'b0, `MT_A_TMR_HI)) begin
            tc_lo_q <= tcnt_q[3:0]; // [R3]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ports
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            data_q <= '0;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `MT_A_PORT_A: data_q.a <= bus_req.wdata;
                `MT_A_PORT_B: data_q.b <= bus_req.wdata;
                `MT_A_PORT_C: data_q.c <= bus_req.wdata;
                `MT_A_PORT_D: data_q.d <= bus_req.wdata[2:0];
                `MT_A_PORT_E: data_q.e <= bus_req.wdata[1:0];
                default: data_q <= data_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            dir_q <= '0; // [R6]
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `MT_A_DIR_A: dir_q.a <= bus_req.wdata;
                `MT_A_DIR_B: dir_q.b <= bus_req.wdata;
                `MT_A_DIR_C: dir_q.c <= bus_req.wdata;
                `MT_A_DIR_D: dir_q.d <= {bus_req.wdata[2:1], 1'b0}; // [R7]
                `MT_A_DIR_E: dir_q.e <= bus_req.wdata[1:0]; // [R7]
                default: dir_q <= dir_q;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pull_en_q <= 1'b0; // [R9]
            csel_q    <= 3'h0;
        end else if (hit(bus_req, 1'b1, `MT_A_PULL)) begin
            pull_en_q <= bus_req.wdata[`MT_B_PULL]; // [R9]
            csel_q    <= bus_req.wdata[2:0];
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pin_out      <= '0;
            pin_oe       <= '0;
            pin_pull_low <= '0;
        end else begin
            pin_out      <= data_q;
            pin_oe       <= dir_q; // [R6]
            pin_pull_low <= pull_en_q ? data_q : '0; // [R8]
        end
    end

    // outputs read back their latch, inputs read the synchronised pin
    assign port_val = (dir_q & data_q) | (~dir_q & pin_sync_q);

    ////////////////////////////////////////////////////////////////////////
    // port interrupt: only input pins take part
    assign src[10:7] = ~dir_q.b & pin_sync_q.b; // [R10]
    assign src[6:3]  = ~dir_q.c & pin_sync_q.c; // [R10]
    assign src[2:0]  = opt_sync_q ? (~dir_q.d & pin_sync_q.d) : 3'h0; // [R11]
    assign pin_set   = armed_q && |(src & ~src_prev_q);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            src_prev_q <= 11'h000;
            armed_q    <= 1'b1;
        end else begin
            // raw synchronised levels: turning a high pin into an input is no edge
            src_prev_q <= {pin_sync_q.b, pin_sync_q.c, pin_sync_q.d};
            if (pin_set) begin
                armed_q <= 1'b0; // [R12]
            end else if (src == 11'h000) begin
                armed_q <= 1'b1; // [R12]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // carrier synthesizer
    assign tick_c    = presc_tick(csel_q, div_q); // [R13]
    assign carr_wrap = tick_c && (ccnt_q == `MT_CNT_WRAP) && !carr_wr;

    always_comb begin
        low_w_d  = low_w_q;
        high_w_d = high_w_q;
        carr_wr  = 1'b0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                `MT_A_CLW_LO: begin
                    low_w_d[3:0] = bus_req.wdata;
                    carr_wr      = 1'b1;
                end
                `MT_A_CLW_HI: begin
                    low_w_d[7:4] = bus_req.wdata;
                    carr_wr      = 1'b1;
                end
                `MT_A_CHW_LO: begin
                    high_w_d[3:0] = bus_req.wdata;
                    carr_wr       = 1'b1;
                end
                `MT_A_CHW_HI: begin
                    high_w_d[7:4] = bus_req.wdata;
                    carr_wr       = 1'b1;
                end
                default: carr_wr = 1'b0;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            low_w_q  <= `MT_RST_BYTE;
            high_w_q <= `MT_RST_BYTE;
        end else begin
            low_w_q  <= low_w_d; // [R14]
            high_w_q <= high_w_d; // [R14]
        end
    end

    // phase_q high means the high-width phase; reset enters it with the high reload
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ccnt_q  <= `MT_RST_BYTE; // [R16]
            phase_q <= 1'b1; // [R16]
        end else if (carr_wr) begin
            ccnt_q <= phase_q ? high_w_d : low_w_d; // [R15]
        end else if (carr_wrap) begin
            ccnt_q  <= phase_q ? low_w_q : high_w_q; // [R17]
            phase_q <= ~phase_q; // [R17]
        end else if (tick_c) begin
            ccnt_q <= ccnt_q + 8'h01; // [R14]
        end
    end

    // the control bit gates the wave so the emitter stays dark until software asks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            carrier_output_ctl_bit_q      <= 1'b0;
            carrier_out <= 1'b0;
        end else begin
            if (hit(bus_req, 1'b1, `MT_A_CARR_OUT)) begin
                carrier_output_ctl_bit_q <= bus_req.wdata[0]; // [R18]
            end
            carrier_out <= carrier_output_ctl_bit_q & phase_q; // [R17]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupt flags and entry
    assign pend_t = ie_tmr_q && rq_tmr_q;
    assign pend_p = ie_pin_q && rq_pin_q;

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ie_tmr_q <= 1'b0; // [R19]
            ie_pin_q <= 1'b0;
        end else if (pend_t || pend_p) begin
            ie_tmr_q <= 1'b0; // [R22]
            ie_pin_q <= 1'b0; // [R22]
        end else if (hit(bus_req, 1'b1, `MT_A_IRQ_EN)) begin
            ie_tmr_q <= bus_req.wdata[`MT_B_TMR_IRQ]; // [R20]
            ie_pin_q <= bus_req.wdata[`MT_B_PIN_IRQ]; // [R20]
        end
    end

    // a hardware set in the same cycle as a software clear wins
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rq_tmr_q <= 1'b0; // [R19]
            rq_pin_q <= 1'b0;
        end else if (hit(bus_req, 1'b1, `MT_A_IRQ_REQ)) begin
            rq_tmr_q <= bus_req.wdata[`MT_B_TMR_IRQ] | tmr_wrap; // [R24]
            rq_pin_q <= bus_req.wdata[`MT_B_PIN_IRQ] | pin_set; // [R24]
        end else begin
            rq_tmr_q <= rq_tmr_q | tmr_wrap; // [R4]
            rq_pin_q <= rq_pin_q | pin_set; // [R10]
        end
    end

    // entry pulse tells the core to push pc and carry, leave halt and jump
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_entry.entry  <= 1'b0;
            irq_entry.vector <= `MT_VEC_RESET; // [R23]
        end else begin
            irq_entry.entry <= pend_t || pend_p; // [R21] [R4]
            if (pend_t) begin
                irq_entry.vector <= `MT_VEC_TMR; // [R23]
            end else if (pend_p) begin
                irq_entry.vector <= `MT_VEC_PIN; // [R23]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read port
    always_comb begin
        case (bus_req.addr)
            `MT_A_IRQ_EN:    rd_mux = {1'b0, ie_tmr_q, 1'b0, ie_pin_q};
            `MT_A_IRQ_REQ:   rd_mux = {1'b0, rq_tmr_q, 1'b0, rq_pin_q};
            `MT_A_TMR_PRESC: rd_mux = {1'b0, tsel_q};
            `MT_A_TMR_LO:    rd_mux = tc_lo_q; // [R3]
            `MT_A_TMR_HI:    rd_mux = tcnt_q[7:4]; // [R3]
            `MT_A_PORT_A:    rd_mux = port_val.a;
            `MT_A_PORT_B:    rd_mux = port_val.b;
            `MT_A_PORT_C:    rd_mux = port_val.c;
            `MT_A_PORT_D:    rd_mux = {1'b0, port_val.d};
            `MT_A_PORT_E:    rd_mux = {2'b00, port_val.e};
            `MT_A_CARR_OUT:  rd_mux = {3'b000, carrier_out}; // [R18]
            `MT_A_PULL:      rd_mux = {pull_en_q, csel_q};
            `MT_A_DIR_A:     rd_mux = dir_q.a;
            `MT_A_DIR_B:     rd_mux = dir_q.b;
            `MT_A_DIR_C:     rd_mux = dir_q.c;
            `MT_A_DIR_D:     rd_mux = {1'b0, dir_q.d};
            `MT_A_DIR_E:     rd_mux = {2'b00, dir_q.e};
            `MT_A_CLW_LO:    rd_mux = low_w_q[3:0];
            `MT_A_CLW_HI:    rd_mux = low_w_q[7:4];
            `MT_A_CHW_LO:    rd_mux = high_w_q[3:0];
            `MT_A_CHW_HI:    rd_mux = high_w_q[7:4];
            default:         rd_mux = 4'h0;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= 4'h0;
        end else begin
            bus_rdata <= bus_req.rd ? rd_mux : 4'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);

    sequence s_tmr_wrap;
        tick_t && (tcnt_q == `MT_CNT_WRAP) && !tmr_wr_hi;
    endsequence
    sequence s_both_pending;
        pend_t && pend_p;
    endsequence

    property p_tmr_commit;
        tmr_wr_hi |=> tcnt_q == reload_q;
    endproperty
    a_tmr_commit: assert property (p_tmr_commit) else $error("reload not committed"); // [R2]

    property p_tmr_wrap;
        s_tmr_wrap |=> (tcnt_q == $past(reload_q)) && rq_tmr_q;
    endproperty
    a_tmr_wrap: assert property (p_tmr_wrap) else $error("timer wrap wrong"); // [R4]

    property p_tmr_pair;
        hit(bus_req, 1'b0, `MT_A_TMR_HI) |=> bus_rdata == $past(tcnt_q[7:4]) && tc_lo_q == $past(tcnt_q[3:0]);
    endproperty
    a_tmr_pair: assert property (p_tmr_pair) else $error("count pair torn"); // [R3]

    property p_dir_d0;
        dir_q.d[0] == 1'b0 && pin_oe.d[0] == 1'b0;
    endproperty
    a_dir_d0: assert property (p_dir_d0) else $error("port d bit0 driven"); // [R7]

    property p_pin_once;
        (!armed_q && src != 11'h000) |=> !armed_q && !pin_set;
    endproperty
    a_pin_once: assert property (p_pin_once) else $error("port irq re-armed early"); // [R12]

    property p_carr_flip;
        carr_wrap |=> (phase_q != $past(phase_q)) ##1 carrier_out == ($past(carrier_output_ctl_bit_q) & !$past(phase_q, 2));
    endproperty
    a_carr_flip: assert property (p_carr_flip) else $error("carrier phase not switched"); // [R17]

    property p_entry_clears;
        (pend_t || pend_p) |=> irq_entry.entry && !ie_tmr_q && !ie_pin_q;
    endproperty
    a_entry_clears: assert property (p_entry_clears) else $error("entry did not clear enables"); // [R22]

    property p_priority;
        s_both_pending |=> irq_entry.vector == `MT_VEC_TMR;
    endproperty
    a_priority: assert property (p_priority) else $error("wrong vector priority"); // [R23]

    property p_pull;
        ##1 pin_pull_low == ($past(pull_en_q) ? $past(data_q) : '0);
    endproperty
    a_pull: assert property (p_pull) else $error("pull-low mismatch"); // [R8]

endmodule
`default_nettype wire

// *** verif/mt_pins_model.sv ***
// Purpose: board side of the port pins
// Assumes: undriven pins take the level the bench puts on the board
// Notes:   no pull-low resistance modelled, a driven pin always wins
`timescale 1ns/10ps
`default_nettype none
module mt_pins_model (
    // from the chip
    input  wire mt_pkg::mt_pins_t pin_out,
    input  wire mt_pkg::mt_pins_t pin_oe,
    // board side
    input  wire mt_pkg::mt_pins_t ext_lvl,
    output var  mt_pkg::mt_pins_t pin_lvl
);
    assign pin_lvl = mt_pkg::mt_pins_t'((pin_out & pin_oe) | (ext_lvl & ~pin_oe));
endmodule
`default_nettype wire

// *** verif/tb_mcu_timer_port_carrier_irq.sv ***
// Purpose: self-checking bench of the peripheral cluster
// Assumes: one-cycle strobe register port, read data in the next cycle
// Notes:   read results are checked from a queue by a monitor process
`timescale 1ns/10ps
`default_nettype none
module tb_mcu_timer_port_carrier_irq;
    logic                  core_clk = 1'b0;
    logic                  arst_n = 1'b0;
    mt_pkg::mt_bus_req_t   bus_req = '0;
    logic [3:0]            bus_rdata;
    mt_pkg::mt_pins_t      ext_lvl = '0;
    mt_pkg::mt_pins_t      pin_lvl, pin_out, pin_oe, pin_pull_low;
    logic                  opt_port_d_irq = 1'b0;
    logic                  carrier_out;
    mt_pkg::mt_irq_entry_t irq_entry;
    logic [3:0]            exp_q[$];
    logic                  rd_d = 1'b0;
    logic [3:0]            r;
    int                    miscompares = 0;
    int                    cmp_count = 0;
    int                    n;
    int                    i;
    always #12.5 core_clk = ~core_clk;
    mt_periph u_mt_periph (.core_clk(core_clk), .arst_n(arst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .pin_in(pin_lvl), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_low(pin_pull_low),
        .opt_port_d_irq(opt_port_d_irq), .carrier_out(carrier_out), .irq_entry(irq_entry));
    mt_pins_model u_mt_pins_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_lvl(pin_lvl));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [16:0] got, input logic [16:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // strobes are left up; idle drops them so no signal is assigned twice per step
    task automatic wr(input logic [4:0] a, input logic [3:0] d);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [4:0] a, input logic [3:0] e);
        exp_q.push_back(e);
        bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 4'h0};
        @(posedge core_clk);
    endtask
    task automatic idle(input int c);
        bus_req <= '0;
        repeat (c) @(posedge core_clk);
    endtask
    task automatic wait_entry(input logic [9:0] v);
        idle(1);
        for (i = 0; i < 200 && irq_entry.entry !== 1'b1; i++) @(posedge core_clk);
        chk(irq_entry.entry, 1'b1);
        chk(irq_entry.vector, v);
    endtask
    always @(posedge core_clk) begin
        rd_d <= bus_req.rd;
        if (rd_d) begin
            if (exp_q.size() == 0) chk(1'b1, 1'b0);
            else chk(bus_rdata, exp_q.pop_front());
        end
    end
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        #(25ns * 20000);
        miscompares++;
        complete_run();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(81));
        repeat (6) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        chk(pin_oe, 17'h0);
        chk(irq_entry.vector, 10'h000);
        rd(5'h00, 4'h0);
        rd(5'h01, 4'h0);
        rd(5'h16, 4'h0);
        wr(5'h19, 4'hf);
        rd(5'h19, 4'h6);
        wr(5'h03, 4'hf);
        rd(5'h03, 4'h0);
        r = 4'($urandom);
        wr(5'h01, r);
        rd(5'h01, r & 4'h5);
        wr(5'h01, 4'h0);
        wr(5'h00, r);
        rd(5'h00, r & 4'h5);
        wr(5'h00, 4'h0);
        idle(3);
        chk(pin_oe, 17'h00018);
        wr(5'h19, 4'h0);
        $display("register test done");
        // low nibble first, high commits; count read high first
        wr(5'h04, 4'ha);
        wr(5'h05, 4'h5);
        rd(5'h05, 4'h5);
        rd(5'h04, 4'ha);
        wr(5'h02, 4'h7);
        wr(5'h04, 4'he);
        wr(5'h05, 4'hf);
        wr(5'h00, 4'h4);
        wait_entry(10'h002);
        rd(5'h00, 4'h0);
        rd(5'h01, 4'h4);
        wr(5'h02, 4'h0);
        wr(5'h04, 4'h0);
        wr(5'h05, 4'h0);
        wr(5'h01, 4'h0);
        rd(5'h01, 4'h0);
        $display("timer test done");
        wr(5'h09, 4'h4);
        wr(5'h17, 4'h4);
        idle(6);
        rd(5'h01, 4'h0);
        wr(5'h17, 4'h0);
        ext_lvl.b[0] <= 1'b1;
        idle(6);
        rd(5'h01, 4'h1);
        wr(5'h00, 4'h1);
        wait_entry(10'h004);
        rd(5'h00, 4'h0);
        wr(5'h01, 4'h0);
        ext_lvl.b[1] <= 1'b1;
        idle(6);
        rd(5'h01, 4'h0);
        ext_lvl <= '0;
        idle(6);
        ext_lvl.c[2] <= 1'b1;
        idle(6);
        rd(5'h01, 4'h1);
        wr(5'h01, 4'h0);
        ext_lvl <= '0;
        idle(6);
        ext_lvl.d[0] <= 1'b1;
        idle(6);
        rd(5'h01, 4'h0);
        ext_lvl <= '0;
        opt_port_d_irq <= 1'b1;
        idle(6);
        ext_lvl.d[0] <= 1'b1;
        idle(6);
        rd(5'h01, 4'h1);
        wr(5'h01, 4'h0);
        ext_lvl <= '0;
        opt_port_d_irq <= 1'b0;
        $display("port irq test done");
        r = 4'($urandom);
        wr(5'h08, r);
        wr(5'h13, 4'h8);
        idle(3);
        chk(pin_pull_low.a, r);
        chk(pin_out.a, r);
        rd(5'h13, 4'h8);
        wr(5'h13, 4'h0);
        idle(3);
        chk(pin_pull_low.a, 4'h0);
        $display("pull-low test done");
        // high reload fc gives 4 ticks, low reload fa gives 6
        wr(5'h1b, 4'ha);
        wr(5'h1c, 4'hf);
        wr(5'h1d, 4'hc);
        wr(5'h1e, 4'hf);
        wr(5'h13, 4'h7);
        wr(5'h0d, 4'h1);
        idle(1);
        // the first high phase is cut short by the control write, so let it pass
        for (i = 0; i < 100 && carrier_out !== 1'b1; i++) @(posedge core_clk);
        for (i = 0; i < 100 && carrier_out !== 1'b0; i++) @(posedge core_clk);
        for (i = 0; i < 100 && carrier_out !== 1'b1; i++) @(posedge core_clk);
        for (n = 0; n < 100 && carrier_out === 1'b1; n++) @(posedge core_clk);
        chk(17'(n), 17'd4);
        for (n = 0; n < 100 && carrier_out === 1'b0; n++) @(posedge core_clk);
        chk(17'(n), 17'd6);
        wr(5'h0d, 4'h0);
        idle(3);
        rd(5'h0d, 4'h0);
        idle(2);
        chk(carrier_out, 1'b0);
        $display("carrier test done");
        complete_run();
    end
endmodule
`default_nettype wire
